//--- logic/mcoa_pkg.sv
package mcoa_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the register port)
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;
    localparam int          ACC_W          = 48;
    localparam logic [4:0]  OFF_CONTROL    = 5'h00;
    localparam logic [4:0]  OFF_OPERAND_A  = 5'h01;
    localparam logic [4:0]  OFF_OPERAND_B  = 5'h02;
    localparam logic [4:0]  OFF_ACC_HIGH   = 5'h03;
    localparam logic [4:0]  OFF_ACC_MIDDLE = 5'h04;
    localparam logic [4:0]  OFF_ACC_LOW    = 5'h05;
    localparam logic [4:0]  OFF_IRQ_STATUS = 5'h0A;
    localparam logic [4:0]  OFF_IRQ_MASK   = 5'h0B;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_SIGNED   = 0;
    localparam int BIT_ACCUM    = 1;
    localparam int BIT_NEGATE   = 2;
    localparam int BIT_SINGLE   = 3;
    localparam int BIT_SQUARE   = 4;
    localparam int BIT_CLEAR    = 5;
    localparam int BIT_INHIBIT  = 6;
    localparam int BIT_OVERFLOW = 7;
    localparam int BIT_DIVIDE   = 8;

    // Interrupt status / mask fields
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_OVF      = 1;
    localparam int IRQ_W        = 2;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [47:0] RST_ACC       = 48'h0000_0000_0000;
    localparam int          MUL_CYCLES    = 2;

    typedef struct packed {
        logic divide_enable;
        logic result_write_inhibit;
        logic square_enable;
        logic single_operand_trigger;
        logic negate_select;
        logic accumulate_select;
        logic signedness_select;
    } mcoa_ctrl_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mcoa_bus_req_t;

    typedef enum logic [1:0] {
        MCOA_IDLE = 2'b01,
        MCOA_BUSY = 2'b10
    } mcoa_state_t;

endpackage : mcoa_pkg

//--- logic/mcoa_top.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps

// Functional notes
// [RL1] Clear_all zeroes data, overflow, sequence counter
// [RL2] Clear_all self-clears after acting
// [RL3] Clear_all aborts an operation in progress
// [RL4] Writing clear_all as zero does nothing
// [RL5] Inhibit discards multiply result, accumulator kept
// [RL6] Inhibit affects only multiplication
// [RL7] Overflow flag set on overflowing operation
// [RL8] Overflow cleared on reset, start, clear
// [RL9] Software never writes one to bit 8
// [RL10] Control bits 15 to 9 read zero
// [RL11] Operand A resets to zero
// [RL12] Operand A full 16-bit read/write
// [RL13] Operand loading starts selected operation
// [RL14] Signedness bit selects signed or unsigned
// [RL15] Result stored in accumulator words
// [RL16] Trigger bit: both operands or either one
// [RL17] Square: write loads both, starts square
// [RL18] Accumulator 48 bits, high word first
// [RL19] Clear wins over same-cycle operand write
module mcoa_top
#(
    parameter int OP_CYCLES = mcoa_pkg::MUL_CYCLES  // Cycles per operation
)
(
    input  wire logic                  ref_clk,    // Core clock
    input  wire logic                  sys_rst,    // Sync reset, high
    input  wire mcoa_pkg::mcoa_bus_req_t bus_req,  // Register request
    output logic [15:0]                rdata,      // Read data, next cycle
    output logic                       irq,        // Level interrupt
    output logic                       op_busy,    // Operation in progress
    output logic                       op_done     // Result cycle pulse
);
    import mcoa_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    mcoa_ctrl_t           ctrl;
    logic                 overflow_flag;
    logic [DATA_W-1:0]    operand_a;
    logic [DATA_W-1:0]    operand_b;
    logic [ACC_W-1:0]     accumulator;
    logic                 a_loaded;
    logic                 b_loaded;
    mcoa_state_t          state;
    logic [7:0]           cycle_cnt;
    mcoa_ctrl_t           op_ctrl;
    logic [DATA_W-1:0]    op_a;
    logic [DATA_W-1:0]    op_b;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic wr_hit(input mcoa_bus_req_t r,
                                    input logic [4:0] off);
        wr_hit = r.wr && (r.addr == off);
    endfunction : wr_hit

    function automatic logic [ACC_W-1:0] widen(input logic [31:0] p,
                                                input logic sgn);
        widen = sgn ? {{16{p[31]}}, p} : {16'h0000, p};
    endfunction : widen

    logic clear_now;
    logic wr_a;
    logic wr_b;
    logic trigger;
    logic finish;

    // Only a one in the clear bit acts; the bit is never stored
    assign clear_now = wr_hit(bus_req, OFF_CONTROL)
                       && bus_req.wdata[BIT_CLEAR];        // [RL4] [RL2]
    assign wr_a = wr_hit(bus_req, OFF_OPERAND_A) && !clear_now; // [RL19]
    assign wr_b = wr_hit(bus_req, OFF_OPERAND_B) && !clear_now; // [RL19]

    // Square overrides the operand count select
    always_comb
    begin
        if (clear_now)
            trigger = 1'b0;                                 // [RL19]
        else if (ctrl.square_enable)
            trigger = wr_a || wr_b;                         // [RL17]
        else if (ctrl.single_operand_trigger)
            trigger = wr_a || wr_b;                         // [RL16]
        else
            trigger = (wr_a || a_loaded) && (wr_b || b_loaded)
                      && (wr_a || wr_b);                    // [RL16] [RL13]
    end

    assign finish  = (state == MCOA_BUSY) && (cycle_cnt == 8'd1);
    assign op_busy = (state == MCOA_BUSY);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl <= '0;
        else if (wr_hit(bus_req, OFF_CONTROL))
        begin
            // Divide bit is kept but drives nothing; software must
            // leave it zero since the divider is not usable.
            ctrl.divide_enable          <= bus_req.wdata[BIT_DIVIDE]; // [RL9]
            ctrl.result_write_inhibit   <= bus_req.wdata[BIT_INHIBIT];
            ctrl.square_enable          <= bus_req.wdata[BIT_SQUARE];
            ctrl.single_operand_trigger <= bus_req.wdata[BIT_SINGLE];
            ctrl.negate_select          <= bus_req.wdata[BIT_NEGATE];
            ctrl.accumulate_select      <= bus_req.wdata[BIT_ACCUM];
            ctrl.signedness_select      <= bus_req.wdata[BIT_SIGNED];
        end
    end

    // ------------------------------------------------------------
    // Operand registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now)
            operand_a <= RST_WORD;                          // [RL11] [RL1]
        else if (wr_a || (wr_b && ctrl.square_enable))
            operand_a <= bus_req.wdata;                     // [RL12] [RL17]
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now)
            operand_b <= RST_WORD;                          // [RL1]
        else if (wr_b || (wr_a && ctrl.square_enable))
            operand_b <= bus_req.wdata;                     // [RL17]
    end

    // Sequence counter: which operands have been written since the
    // last start
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now || trigger)
        begin
            a_loaded <= 1'b0;                               // [RL1]
            b_loaded <= 1'b0;
        end
        else
        begin
            if (wr_a)
                a_loaded <= 1'b1;
            if (wr_b)
                b_loaded <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    // A new trigger while busy restarts with the fresh operands;
    // the older operation is dropped rather than queued.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now)
        begin
            state     <= MCOA_IDLE;                         // [RL3]
            cycle_cnt <= 8'd0;
        end
        else
        begin
            case (state)
                MCOA_IDLE:
                begin
                    if (trigger)
                    begin
                        state     <= MCOA_BUSY;             // [RL13]
                        cycle_cnt <= 8'(OP_CYCLES);
                    end
                end
                MCOA_BUSY:
                begin
                    if (trigger)
                        cycle_cnt <= 8'(OP_CYCLES);
                    else if (finish)
                    begin
                        state     <= MCOA_IDLE;
                        cycle_cnt <= 8'd0;
                    end
                    else
                        cycle_cnt <= cycle_cnt - 8'd1;
                end
                default:
                begin
                    state     <= MCOA_IDLE;
                    cycle_cnt <= 8'd0;
                end
            endcase
        end
    end

    // Operands and mode are frozen at start; later control or operand writes change
    // them only by starting a new operation or by a clear. The accumulator is still read live
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now)
        begin
            op_ctrl <= '0;
            op_a    <= RST_WORD;
            op_b    <= RST_WORD;
        end
        else if (trigger)
        begin
            op_ctrl <= ctrl;
            op_a    <= (ctrl.square_enable || wr_a) ? bus_req.wdata
                                                    : operand_a;
            op_b    <= (ctrl.square_enable || wr_b) ? bus_req.wdata
                                                    : operand_b;
        end
    end

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    logic [31:0]      product;
    logic [ACC_W-1:0] prod_wide;
    logic [ACC_W-1:0] lhs;
    logic [ACC_W:0]   sum_ext;
    logic [ACC_W-1:0] result;
    logic             ovf;

    always_comb
    begin
        if (op_ctrl.signedness_select)
            product = 32'($signed(op_a) * $signed(op_b));   // [RL14]
        else
            product = 32'(op_a * op_b);                     // [RL14]
        prod_wide = widen(product, op_ctrl.signedness_select);
        lhs = op_ctrl.accumulate_select ? accumulator : RST_ACC;
        if (op_ctrl.negate_select)
            sum_ext = {1'b0, lhs} - {1'b0, prod_wide};
        else
            sum_ext = {1'b0, lhs} + {1'b0, prod_wide};
        result = sum_ext[ACC_W-1:0];
        // Signed: sign rule of add/sub; unsigned: carry or borrow
        if (op_ctrl.signedness_select)
        begin
            if (op_ctrl.negate_select)
                ovf = (lhs[ACC_W-1] != prod_wide[ACC_W-1])
                      && (result[ACC_W-1] != lhs[ACC_W-1]);
            else
                ovf = (lhs[ACC_W-1] == prod_wide[ACC_W-1])
                      && (result[ACC_W-1] != lhs[ACC_W-1]);
        end
        else
            ovf = sum_ext[ACC_W];
    end

    assign op_done = finish && !wr_a && !wr_b;

    // ------------------------------------------------------------
    // Accumulator (high, middle, low words)
    // ------------------------------------------------------------
    // A software word write in the finishing cycle is dropped and the result
    // is written unless inhibited; the operation owns the accumulator then.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now)
            accumulator <= RST_ACC;                         // [RL1]
        else if (op_done)
        begin
            if (!op_ctrl.result_write_inhibit)
                accumulator <= result;                      // [RL15] [RL5]
        end                                                 // [RL6]
        else
        begin
            if (wr_hit(bus_req, OFF_ACC_HIGH))
                accumulator[47:32] <= bus_req.wdata;        // [RL18]
            if (wr_hit(bus_req, OFF_ACC_MIDDLE))
                accumulator[31:16] <= bus_req.wdata;
            if (wr_hit(bus_req, OFF_ACC_LOW))
                accumulator[15:0]  <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear_now || trigger)
            overflow_flag <= 1'b0;                          // [RL8] [RL1]
        else if (op_done && ovf)
            overflow_flag <= 1'b1;                          // [RL7]
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic             stat_rd;

    assign stat_rd = bus_req.rd && (bus_req.addr == OFF_IRQ_STATUS);

    always_comb
    begin
        irq_set           = '0;
        irq_set[IRQ_DONE] = op_done;
        irq_set[IRQ_OVF]  = op_done && ovf;
    end

    // Set wins over the read-clear so no event is lost
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_status <= '0;
        else if (stat_rd)
            irq_status <= irq_set;
        else
            irq_status <= irq_status | irq_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_mask <= '0;
        else if (wr_hit(bus_req, OFF_IRQ_MASK))
            irq_mask <= bus_req.wdata[IRQ_W-1:0];
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [15:0] ctrl_word;

    always_comb
    begin
        ctrl_word               = 16'h0000;                 // [RL10]
        ctrl_word[BIT_SIGNED]   = ctrl.signedness_select;
        ctrl_word[BIT_ACCUM]    = ctrl.accumulate_select;
        ctrl_word[BIT_NEGATE]   = ctrl.negate_select;
        ctrl_word[BIT_SINGLE]   = ctrl.single_operand_trigger;
        ctrl_word[BIT_SQUARE]   = ctrl.square_enable;
        ctrl_word[BIT_INHIBIT]  = ctrl.result_write_inhibit;
        ctrl_word[BIT_OVERFLOW] = overflow_flag;
        ctrl_word[BIT_DIVIDE]   = ctrl.divide_enable;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata <= RST_WORD;
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                OFF_CONTROL:    rdata <= ctrl_word;
                OFF_OPERAND_A:  rdata <= operand_a;         // [RL12]
                OFF_OPERAND_B:  rdata <= operand_b;
                OFF_ACC_HIGH:   rdata <= accumulator[47:32];
                OFF_ACC_MIDDLE: rdata <= accumulator[31:16];
                OFF_ACC_LOW:    rdata <= accumulator[15:0];
                OFF_IRQ_STATUS: rdata <= {14'h0000, irq_status};
                OFF_IRQ_MASK:   rdata <= {14'h0000, irq_mask};
                default:        rdata <= RST_WORD;
            endcase
        end
        else
            rdata <= RST_WORD;
    end

endmodule : mcoa_top

//--- sim/mcoa_host.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Core side register master
// ------------------------------------------------------------
module mcoa_host
(
    input  wire logic              ref_clk, // Core clock
    output mcoa_pkg::mcoa_bus_req_t bus_req  // Register request
);
    import mcoa_pkg::*;
    initial bus_req = '0;
    // Released lines show the inverse so stale values are never trusted
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [15:0] d);
        @(posedge ref_clk);
        // Divide bit is kept clear on control writes only
        bus_req <= '{addr: a,
                     wdata: (a == OFF_CONTROL) ? (d & 16'hFEFF) : d,
                     wr: w,
                     rd: !w};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : xfer
endmodule : mcoa_host

//--- sim/mcoa_top_chk.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks for control reads, read data, clear and operation timing
// ------------------------------------------------------------
module mcoa_top_chk
#(
    parameter int OP_CYCLES = mcoa_pkg::MUL_CYCLES // Cycles per operation
)
(
    input wire logic                    ref_clk, // Core clock
    input wire logic                    sys_rst, // Sync reset, high
    input wire mcoa_pkg::mcoa_bus_req_t bus_req, // Register request
    input wire logic [15:0]             rdata,   // Read data
    input wire logic                    irq,     // Level interrupt
    input wire logic                    op_busy, // Operation running
    input wire logic                    op_done  // Result pulse
);
    import mcoa_pkg::*;
    localparam int LAT = OP_CYCLES - 1;
    logic [1:0] trig_mode; // Shadow of square and single bits
    logic       clr_hit;   // Clear seen since the last operand write
    logic       wr_ctl;
    logic       wr_opd;
    assign wr_ctl = bus_req.wr && bus_req.addr == OFF_CONTROL;
    assign wr_opd = bus_req.wr && (bus_req.addr == OFF_OPERAND_A
                    || bus_req.addr == OFF_OPERAND_B);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            trig_mode <= 2'h0;
        else if (wr_ctl)
            trig_mode <= bus_req.wdata[BIT_SQUARE:BIT_SINGLE];
    end
    // An aborted run ends without a result pulse
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            clr_hit <= 1'b0;
        else if (wr_ctl && bus_req.wdata[BIT_CLEAR])
            clr_hit <= 1'b1;
        else if (wr_opd)
            clr_hit <= 1'b0;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    property p_rsvd;
        bus_req.rd && bus_req.addr == OFF_CONTROL |=> rdata[15:9] == 7'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("control reserved bits not zero");
    property p_clr_self;
        bus_req.rd && bus_req.addr == OFF_CONTROL |=> !rdata[BIT_CLEAR];
    endproperty
    a_clr_self: assert property (p_clr_self)
        else $error("clear bit reads back set");
    property p_rd_idle;
        !bus_req.rd |=> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    property p_clr_abort;
        wr_ctl && bus_req.wdata[BIT_CLEAR] |=> !op_busy && !op_done;
    endproperty
    a_clr_abort: assert property (p_clr_abort)
        else $error("clear did not stop operation");
    property p_zero_keep;
        wr_ctl && !bus_req.wdata[BIT_CLEAR] && op_busy && !op_done
            |=> op_busy;
    endproperty
    a_zero_keep: assert property (p_zero_keep)
        else $error("zero clear write disturbed operation");
    property p_trig;
        wr_opd && trig_mode != 2'h0 |=> op_busy;
    endproperty
    a_trig: assert property (p_trig)
        else $error("operand write did not start operation");
    property p_lat;
        $rose(op_busy) |-> ##LAT (op_done || clr_hit);
    endproperty
    a_lat: assert property (p_lat)
        else $error("result pulse late or missing");
    property p_done_end;
        op_done |-> op_busy ##1 !op_busy;
    endproperty
    a_done_end: assert property (p_done_end)
        else $error("result pulse outside last busy cycle");
    c_abort: cover property (op_busy && wr_ctl && bus_req.wdata[BIT_CLEAR]);
    c_done: cover property (op_done);
    c_irq: cover property ($rose(irq));
endmodule : mcoa_top_chk

bind mcoa_top mcoa_top_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .bus_req (bus_req),
    .rdata   (rdata),
    .irq     (irq),
    .op_busy (op_busy),
    .op_done (op_done)
);

//--- sim/mcoa_top_tb.sv
`timescale 1ns/100ps
module mcoa_top_tb;
    import mcoa_pkg::*;
    localparam int OPC = 4;
    logic          ref_clk = 1'b0;
    logic          sys_rst = 1'b1;
    mcoa_bus_req_t bus_req;
    logic [15:0]   rdata;
    logic          irq;
    logic          op_busy;
    logic          op_done;
    int            fails = 0;
    int            num_checks = 0;
    int            cyc = 0;
    logic          pend = 1'b0;
    logic [15:0]   exp_q[$];
    logic [15:0]   va;
    logic [47:0]   acc;

    always #20 ref_clk = ~ref_clk;

    mcoa_top #(.OP_CYCLES(OPC)) uut (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .bus_req (bus_req),
        .rdata   (rdata),
        .irq     (irq),
        .op_busy (op_busy),
        .op_done (op_done)
    );
    mcoa_host u_host (
        .ref_clk (ref_clk),
        .bus_req (bus_req)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic summarize();
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_host.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 16'h0000);
    endtask : rd
    task automatic rd_acc(input logic [47:0] e);
        rd(OFF_ACC_HIGH, e[47:32]);
        rd(OFF_ACC_MIDDLE, e[31:16]);
        rd(OFF_ACC_LOW, e[15:0]);
    endtask : rd_acc
    task automatic wait_done();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (op_done !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        cmp({15'h0, op_done}, 16'h0001);
        @(posedge ref_clk);
    endtask : wait_done

    // Read data is looked at only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        if (pend)
            cmp(rdata, exp_q.pop_front());
        pend <= bus_req.rd;
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(32'hED75));
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(OFF_OPERAND_A, 16'h0000);
        rd(OFF_CONTROL, 16'h0000);
        rd_acc(48'h0);
        for (int i = 0; i < 4; i++)
        begin
            va = (i == 0) ? 16'hFFFF : 16'($urandom());
            wr(OFF_OPERAND_A, va);
            rd(OFF_OPERAND_A, va);
        end
        @(negedge ref_clk);
        cmp({15'h0, op_busy}, 16'h0000);
        acc = 48'($urandom());
        wr(OFF_OPERAND_B, acc[15:0]);
        wait_done();
        rd_acc(48'(va) * 48'(acc[15:0]));
        rd(OFF_IRQ_STATUS, 16'h0001);
        rd(OFF_IRQ_STATUS, 16'h0000);
        wr(OFF_IRQ_MASK, 16'h0001);
        wr(OFF_CONTROL, 16'h0008);
        wr(OFF_OPERAND_A, 16'h0003);
        wait_done();
        @(negedge ref_clk);
        cmp({15'h0, irq}, 16'h0001);
        wr(OFF_IRQ_MASK, 16'h0000);
        @(negedge ref_clk);
        cmp({15'h0, irq}, 16'h0000);
        rd(OFF_IRQ_STATUS, 16'h0001);
        wr(OFF_OPERAND_B, 16'h0003);
        wait_done();
        // Signed product of -2 and 3 through all four accumulate and negate settings
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_CONTROL, 16'h0009 | 16'(m << 1));
            wr(OFF_OPERAND_A, 16'hFFFE);
            wait_done();
            acc = (m[0] ? acc : 48'h0) + (m[1] ? 48'h6 : -48'h6);
            rd_acc(acc);
        end
        wr(OFF_CONTROL, 16'h0048);
        wr(OFF_OPERAND_A, 16'h0007);
        wait_done();
        rd_acc(acc);
        for (int k = 3; k < 6; k++)
            wr(5'(k), 16'hFFFF);
        wr(OFF_CONTROL, 16'h000A);
        wr(OFF_OPERAND_A, 16'h0001);
        wait_done();
        rd(OFF_CONTROL, 16'h008A);
        rd_acc(48'h2);
        wr(OFF_OPERAND_A, 16'h0000);
        wait_done();
        rd(OFF_CONTROL, 16'h000A);
        wr(OFF_CONTROL, 16'h0010);
        wr(OFF_OPERAND_B, 16'h0005);
        wait_done();
        rd(OFF_OPERAND_A, 16'h0005);
        rd_acc(48'h19);
        wr(OFF_CONTROL, 16'h0008);
        wr(OFF_OPERAND_A, 16'h0009);
        wr(OFF_CONTROL, 16'hFE28);
        @(negedge ref_clk);
        cmp({15'h0, op_busy}, 16'h0000);
        rd(OFF_OPERAND_A, 16'h0000);
        rd(OFF_OPERAND_B, 16'h0000);
        rd_acc(48'h0);
        rd(OFF_CONTROL, 16'h0008);
        wr(OFF_OPERAND_B, 16'h0004);
        wait_done();
        wr(OFF_OPERAND_A, 16'h0002);
        wr(OFF_CONTROL, 16'h0008);
        wait_done();
        rd_acc(48'h8);
        wr(5'h1F, 16'h1234);
        rd(5'h1F, 16'h0000);
        rd(OFF_OPERAND_A, 16'h0002);
        repeat (2) @(posedge ref_clk);
        summarize();
    end
endmodule : mcoa_top_tb
